//--- hdl/synl_core.sv
// latch bank and power-down control of an integer-n synthesizer
// assumes serial pins and reference/phase status arrive asynchronously
`timescale 1ns/1ns
module synl_core
	import synl_pkg::*;
(
	input  wire logic        mclk,               // core clock
	input  wire logic        rst,                // sync reset, high
	input  wire logic        sclk,               // serial link clock
	input  wire logic        sdata,              // serial data pin
	input  wire logic        latch_strobe,       // latch enable pin
	input  wire logic        chip_enable,        // hardware enable pin
	input  wire logic        ref_in,             // reference input pin
	input  wire logic        phase_ok,           // phase error under 15 ns
	output logic [1:0]       prescaler_sel,      // prescaler select
	output logic [2:0]       pump_current,       // active pump current code
	output logic             pump_tristate_out,  // charge pump three-state
	output logic             detector_polarity,  // 1 positive
	output logic [1:0]       output_level,       // rf output level
	output logic [2:0]       outmux_sel,         // observe mux select
	output logic [1:0]       core_bias,          // vco core bias
	output logic [4:0]       swallow_count,      // a counter value
	output logic [12:0]      main_count,         // b counter value
	output logic             output_halve,       // divide-by-2 output
	output logic             halved_feed_select, // halved feed to prescaler
	output logic [13:0]      ref_div_value,      // reference divider value
	output logic [1:0]       antibacklash,       // antibacklash width
	output logic [1:0]       band_clk_div,       // band clock divider
	output logic             factory_test_bit,   // test bit as written
	output logic             counters_load,      // counters held at load
	output logic             ref_div_out,        // reference divider pulse
	output logic             lock_detect,        // digital lock
	output logic             rf_out_en,          // rf outputs enabled
	output logic             ref_buf_en,         // reference buffer enabled
	output logic             band_select_start,  // band selection pulse
	output logic             powered_up          // device active
);
	synl_link_if link ();

	synl_shift u_shift (
		.sclk  (sclk),
		.sdata (sdata),
		.link  (link.shifter)
	);

	// pin synchronisers
	logic [2:0] le_sync_reg;
	logic [1:0] ce_sync_reg;
	logic [2:0] ref_sync_reg;
	logic [1:0] ok_sync_reg;
	always_ff @(posedge mclk) begin
		le_sync_reg  <= {le_sync_reg[1:0], latch_strobe};
		ce_sync_reg  <= {ce_sync_reg[0], chip_enable};
		ref_sync_reg <= {ref_sync_reg[1:0], ref_in};
		ok_sync_reg  <= {ok_sync_reg[0], phase_ok};
	end
	logic le_rise;
	logic ce_on;
	logic ref_rise;
	logic ok_on;
	assign le_rise  = le_sync_reg[1] & ~le_sync_reg[2];
	assign ce_on    = ce_sync_reg[1];
	assign ref_rise = ref_sync_reg[1] & ~ref_sync_reg[2];
	assign ok_on    = ok_sync_reg[1];

	logic [WORD_W-1:0] ctrl_reg,  ctrl_next;
	logic [WORD_W-1:0] ndiv_reg,  ndiv_next;
	logic [WORD_W-1:0] rdiv_reg,  rdiv_next;
	logic              gain_reg,  gain_next;
	synl_pstate_t      ps_reg,    ps_next;
	logic [1:0]        edge_reg,  edge_next;
	logic [13:0]       rcnt_reg,  rcnt_next;
	logic              rpulse_reg, rpulse_next;
	logic [2:0]        lcnt_reg,  lcnt_next;
	logic              ndirty_reg, ndirty_next;
	logic              pwr_reg,   pwr_next;
	logic              band_reg,  band_next;
	logic [2:0]        cur_reg,   cur_next;
	logic              tri_reg,   tri_next;
	logic              rfen_reg,  rfen_next;
	logic              hold_reg,  hold_next;

	logic [1:0]  sel;
	logic [2:0]  lock_need;
	logic        powered;
	logic        locked;
	logic        hold;
	assign sel       = link.word[1:0];
	assign lock_need = rdiv_reg[RL_PREC] ? LOCK_CNT_FINE : LOCK_CNT_COARSE;
	assign locked    = lcnt_reg >= lock_need;

	always_comb begin
		ctrl_next   = ctrl_reg;
		ndiv_next   = ndiv_reg;
		rdiv_next   = rdiv_reg;
		gain_next   = gain_reg;
		ndirty_next = ndirty_reg;
		band_next   = 1'b0;
		if (le_rise) begin
			case (sel)
				SEL_CTRL: begin
					ctrl_next = link.word;
					gain_next = link.word[CT_GAIN];
				end
				SEL_NDIV: begin
					ndiv_next = link.word;
					gain_next = link.word[NL_GAIN];
				end
				SEL_RDIV: rdiv_next = link.word;
				// select 11 (test latch) is ignored, all latches keep values
				default: ;
			endcase
		end
		// power state: software modes, then hardware enable on top
		ps_next   = ps_reg;
		edge_next = edge_reg;
		if (!ctrl_reg[CT_PD_A]) begin
			ps_next = SYNL_PS_RUN;
		end else if (!ctrl_reg[CT_PD_B]) begin
			ps_next = SYNL_PS_DOWN;
		end else begin
			case (ps_reg)
				SYNL_PS_RUN: begin
					ps_next   = SYNL_PS_ARM;
					edge_next = 2'h0;
				end
				SYNL_PS_ARM: begin
					if (rpulse_reg) begin
						edge_next = edge_reg + 2'h1;
						if (edge_reg + 2'h1 == SYNC_PD_EDGES) begin
							ps_next = SYNL_PS_DOWN;
						end
					end
				end
				SYNL_PS_DOWN: ps_next = SYNL_PS_DOWN;
				default: ps_next = SYNL_PS_RUN;
			endcase
		end
		// a new synchronous request restarts the edge count
		if (le_rise && sel == SEL_CTRL && ps_reg == SYNL_PS_ARM) begin
			edge_next = 2'h0;
		end
		powered  = ce_on && ps_reg != SYNL_PS_DOWN;
		pwr_next = powered;
		// band select on n write when active, or on wake after n changed
		if (le_rise && sel == SEL_NDIV) begin
			if (powered) begin
				band_next = 1'b1;
			end else begin
				ndirty_next = 1'b1;
			end
		end
		if (powered && !pwr_reg && ndirty_reg) begin
			band_next   = 1'b1;
			ndirty_next = 1'b0;
		end
		// reference divider
		hold        = !powered || ctrl_reg[CT_CRST];
		hold_next   = hold;
		rcnt_next   = rcnt_reg;
		rpulse_next = 1'b0;
		if (hold) begin
			rcnt_next = 14'h0001;
		end else if (ref_rise) begin
			if (rcnt_reg >= rdiv_reg[RL_R_HI:RL_R_LO]) begin
				rcnt_next   = 14'h0001;
				rpulse_next = 1'b1;
			end else begin
				rcnt_next = rcnt_reg + 14'h0001;
			end
		end
		// lock detector counts good reference cycles
		lcnt_next = lcnt_reg;
		if (!powered) begin
			lcnt_next = 3'h0;
		end else if (rpulse_reg) begin
			if (!ok_on) begin
				lcnt_next = 3'h0;
			end else if (lcnt_reg < LOCK_CNT_FINE) begin
				lcnt_next = lcnt_reg + 3'h1;
			end
		end
		cur_next  = gain_reg ? ctrl_reg[CT_CUR2_HI:CT_CUR2_LO]
		                     : ctrl_reg[CT_CUR1_HI:CT_CUR1_LO];
		tri_next  = !powered || ctrl_reg[CT_TRI];
		rfen_next = powered && (!ctrl_reg[CT_MUTE] || locked);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_reg   <= LATCH_RST;
			ndiv_reg   <= LATCH_RST;
			rdiv_reg   <= LATCH_RST;
			gain_reg   <= 1'b0;
			ps_reg     <= SYNL_PS_RUN;
			edge_reg   <= 2'h0;
			rcnt_reg   <= 14'h0001;
			rpulse_reg <= 1'b0;
			lcnt_reg   <= 3'h0;
			ndirty_reg <= 1'b0;
			pwr_reg    <= 1'b0;
			band_reg   <= 1'b0;
			cur_reg    <= 3'h0;
			tri_reg    <= 1'b1;
			rfen_reg   <= 1'b0;
			hold_reg   <= 1'b1;
		end else begin
			ctrl_reg   <= ctrl_next;
			ndiv_reg   <= ndiv_next;
			rdiv_reg   <= rdiv_next;
			gain_reg   <= gain_next;
			ps_reg     <= ps_next;
			edge_reg   <= edge_next;
			rcnt_reg   <= rcnt_next;
			rpulse_reg <= rpulse_next;
			lcnt_reg   <= lcnt_next;
			ndirty_reg <= ndirty_next;
			pwr_reg    <= pwr_next;
			band_reg   <= band_next;
			cur_reg    <= cur_next;
			tri_reg    <= tri_next;
			rfen_reg   <= rfen_next;
			hold_reg   <= hold_next;
		end
	end

	assign prescaler_sel      = ctrl_reg[CT_PRE_HI:CT_PRE_LO];
	assign pump_current       = cur_reg;
	assign pump_tristate_out  = tri_reg;
	assign detector_polarity  = ctrl_reg[CT_POL];
	assign output_level       = ctrl_reg[CT_LVL_HI:CT_LVL_LO];
	assign outmux_sel         = ctrl_reg[CT_MUX_HI:CT_MUX_LO];
	assign core_bias          = ctrl_reg[CT_BIAS_HI:CT_BIAS_LO];
	assign swallow_count      = ndiv_reg[NL_A_HI:NL_A_LO];
	assign main_count         = ndiv_reg[NL_B_HI:NL_B_LO];
	assign output_halve       = ndiv_reg[NL_HALVE];
	assign halved_feed_select = ndiv_reg[NL_FEED];
	assign ref_div_value      = rdiv_reg[RL_R_HI:RL_R_LO];
	assign antibacklash       = rdiv_reg[RL_ABP_HI:RL_ABP_LO];
	assign band_clk_div       = rdiv_reg[RL_BSC_HI:RL_BSC_LO];
	assign factory_test_bit   = rdiv_reg[RL_TEST];
	assign counters_load      = hold_reg;
	assign ref_div_out        = rpulse_reg;
	assign lock_detect        = locked;
	assign rf_out_en          = rfen_reg;
	assign ref_buf_en         = pwr_reg;
	assign band_select_start  = band_reg;
	assign powered_up         = pwr_reg;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	AST_CTRL_LOAD: assert property (le_rise && sel == SEL_CTRL |=> ctrl_reg == $past(link.word))
		else $error("control latch not loaded");
	AST_N_LOAD: assert property (le_rise && sel == SEL_NDIV |=> ndiv_reg == $past(link.word))
		else $error("n latch not loaded");
	AST_R_LOAD: assert property (le_rise && sel == SEL_RDIV |=> rdiv_reg == $past(link.word))
		else $error("reference latch not loaded");
	AST_CE_OFF: assert property (!ce_on |=> !powered_up && !rf_out_en && pump_tristate_out)
		else $error("chip enable low did not disable");
	AST_ASYNC_PD: assert property (le_rise && sel == SEL_CTRL && link.word[CT_PD_A]
		&& !link.word[CT_PD_B] |=> ##1 ps_reg == SYNL_PS_DOWN ##1 !ref_buf_en)
		else $error("asynchronous power-down late");
	AST_SYNC_PD: assert property (ps_reg == SYNL_PS_ARM && ctrl_reg[CT_PD_A] && ctrl_reg[CT_PD_B]
		&& rpulse_reg && edge_reg == 2'h1 && !le_rise |=> ps_reg == SYNL_PS_DOWN)
		else $error("synchronous power-down not on second pulse");
	AST_PD_CLEAR: assert property (ps_reg == SYNL_PS_DOWN |=> lcnt_reg == 3'h0 && counters_load)
		else $error("power-down did not clear counters");
	AST_PUMP_OFF: assert property (!powered_up |-> pump_tristate_out || $past(powered_up))
		else $error("pump active while down");
	AST_GAIN_SEL: assert property (gain_reg ##1 $stable(ctrl_reg) |-> pump_current
		== ctrl_reg[CT_CUR2_HI:CT_CUR2_LO])
		else $error("gain bit did not pick setting two");
	AST_MUTE: assert property (ctrl_reg[CT_MUTE] && !locked |=> !rf_out_en)
		else $error("rf on before lock with mute");
	AST_CNT_RESET: assert property (ctrl_reg[CT_CRST] |=> rcnt_reg == 14'h0001 && !ref_div_out)
		else $error("counter reset did not hold divider");

	COV_CTRL: cover property (le_rise && sel == SEL_CTRL);
	COV_SYNC_DOWN: cover property (ps_reg == SYNL_PS_ARM ##1 ps_reg == SYNL_PS_DOWN);
	COV_LOCK: cover property (!locked ##1 locked);
	COV_WAKE_BAND: cover property (band_reg && !$past(pwr_reg, 2));
endmodule

//--- hdl/synl_link_if.sv
// carries the shifted serial word from the link-clock shifter to the core
// assumes the word is static while the latch strobe is high
`timescale 1ns/1ns
interface synl_link_if;
	logic [23:0] word;
	modport shifter (output word);
	modport core    (input  word);
endinterface

//--- hdl/synl_pkg.sv
// constants for the synthesizer latch bank and power-down control
// assumes a 24-bit word shifted msb first, latch select in the two lsbs
package synl_pkg;
	localparam int WORD_W     = 24;
	// latch select codes (upper, lower)
	localparam logic [1:0] SEL_CTRL = 2'h0;
	localparam logic [1:0] SEL_RDIV = 2'h1;
	localparam logic [1:0] SEL_NDIV = 2'h2;
	// control latch fields
	localparam int CT_PRE_HI  = 23;
	localparam int CT_PRE_LO  = 22;
	localparam int CT_PD_B    = 21;
	localparam int CT_PD_A    = 20;
	localparam int CT_CUR2_HI = 19;
	localparam int CT_CUR2_LO = 17;
	localparam int CT_CUR1_HI = 16;
	localparam int CT_CUR1_LO = 14;
	localparam int CT_LVL_HI  = 13;
	localparam int CT_LVL_LO  = 12;
	localparam int CT_MUTE    = 11;
	localparam int CT_GAIN    = 10;
	localparam int CT_TRI     = 9;
	localparam int CT_POL     = 8;
	localparam int CT_MUX_HI  = 7;
	localparam int CT_MUX_LO  = 5;
	localparam int CT_CRST    = 4;
	localparam int CT_BIAS_HI = 3;
	localparam int CT_BIAS_LO = 2;
	// n divider latch fields
	localparam int NL_FEED    = 23;
	localparam int NL_HALVE   = 22;
	localparam int NL_GAIN    = 21;
	localparam int NL_B_HI    = 20;
	localparam int NL_B_LO    = 8;
	localparam int NL_A_HI    = 6;
	localparam int NL_A_LO    = 2;
	// reference divider latch fields
	localparam int RL_BSC_HI  = 21;
	localparam int RL_BSC_LO  = 20;
	localparam int RL_TEST    = 19;
	localparam int RL_PREC    = 18;
	localparam int RL_ABP_HI  = 17;
	localparam int RL_ABP_LO  = 16;
	localparam int RL_R_HI    = 15;
	localparam int RL_R_LO    = 2;
	// lock detect qualification counts
	localparam logic [2:0] LOCK_CNT_FINE   = 3'h5;
	localparam logic [2:0] LOCK_CNT_COARSE = 3'h3;
	// reference pulses before synchronous power-down
	localparam logic [1:0] SYNC_PD_EDGES = 2'h2;
	localparam logic [WORD_W-1:0] LATCH_RST = 24'h000000;
	typedef enum logic [1:0] {
		SYNL_PS_RUN  = 2'b00,
		SYNL_PS_ARM  = 2'b01,
		SYNL_PS_DOWN = 2'b10
	} synl_pstate_t;
endpackage

//--- hdl/synl_shift.sv
// serial input shifter on the link clock
// assumes the host stops the serial clock around the latch strobe edge
`timescale 1ns/1ns
module synl_shift
	import synl_pkg::*;
(
	input  wire logic   sclk,    // serial link clock
	input  wire logic   sdata,   // serial data, msb first
	synl_link_if.shifter link    // shifted word out
);
	logic [WORD_W-1:0] shift_reg;
	logic [WORD_W-1:0] shift_next;

	always_comb begin
		shift_next = {shift_reg[WORD_W-2:0], sdata};
	end

	// no reset: keeps shifting through any power-down
	always_ff @(posedge sclk) begin
		shift_reg <= shift_next;
	end

	assign link.word = shift_reg;
endmodule

//--- tb/synl_host.sv
// host model driving the three-wire serial write
// assumes a 10 MHz core: strobe high and low each span several core cycles
`timescale 1ns/1ns
module synl_host (
	output logic sclk,         // serial clock, idle low
	output logic sdata,        // serial data
	output logic latch_strobe  // latch enable
);
	initial begin
		sclk = 1'b0;
		sdata = 1'b0;
		latch_strobe = 1'b0;
	end
	task automatic send(input logic [23:0] w, input bit slow);
		logic [23:0] v;
		v = w;
		if (v[1:0] == 2'h2)
			v[7] = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sdata = v[i];
			#80 sclk = 1'b1;
			#80 sclk = 1'b0;
			if (slow)
				#400;
		end
		sdata = ~v[0];
		#80 latch_strobe = 1'b1;
		#700 latch_strobe = 1'b0;
		#700;
	endtask
endmodule

//--- tb/tb.sv
// self-checking bench for the synthesizer latch bank
// assumes the host model owns the serial pins; bench drives the rest
`timescale 1ns/1ns
module tb;
	import synl_pkg::*;
	typedef struct packed {int k; logic [31:0] v;} synl_note_t;
	logic        mclk = 1'b0, rst, chip_enable, ref_in, phase_ok, ref_run;
	wire logic   sclk, sdata, latch_strobe;
	logic [2:0]  pump_current;
	logic [4:0]  swallow_count;
	logic [12:0] main_count;
	logic [13:0] ref_div_value;
	logic [1:0]  antibacklash, band_clk_div;
	logic        pump_tristate_out, detector_polarity, counters_load, ref_div_out;
	logic        lock_detect, rf_out_en, ref_buf_en, band_select_start, powered_up;
	logic [1:0]  prescaler_sel, output_level, core_bias;
	logic [2:0]  outmux_sel;
	logic        output_halve, halved_feed_select, factory_test_bit;
	int          fails = 0, num_checks = 0, bs_cnt = 0, n;
	synl_note_t  q[$];
	synl_note_t  nt;
	event        obs;
	string nm[20] = '{"rdiv", "abp", "bsc", "acnt", "bcnt", "cur", "tri", "pol", "load",
		"pwr", "rbuf", "rf", "lock", "pre", "lvl", "mux", "bias", "halve", "feed", "test"};
	synl_host host (.sclk, .sdata, .latch_strobe);
	synl_core dut (.mclk, .rst, .sclk, .sdata, .latch_strobe, .chip_enable, .ref_in,
		.phase_ok, .prescaler_sel, .pump_current, .pump_tristate_out, .detector_polarity,
		.output_level, .outmux_sel, .core_bias, .swallow_count, .main_count,
		.output_halve, .halved_feed_select, .ref_div_value, .antibacklash,
		.band_clk_div, .factory_test_bit, .counters_load, .ref_div_out, .lock_detect,
		.rf_out_en, .ref_buf_en, .band_select_start, .powered_up);
	always #50 mclk = ~mclk;
	always @(posedge mclk) begin
		if (ref_run)
			ref_in <= ~ref_in;
	end
	// band pulse counted mid-cycle, away from the edge that launches it
	always @(negedge mclk) begin
		if (band_select_start === 1'b1)
			bs_cnt++;
	end
	function automatic logic [31:0] ov(input int k);
		case (k)
			0: return 32'(ref_div_value);
			1: return 32'(antibacklash);
			2: return 32'(band_clk_div);
			3: return 32'(swallow_count);
			4: return 32'(main_count);
			5: return 32'(pump_current);
			6: return 32'(pump_tristate_out);
			7: return 32'(detector_polarity);
			8: return 32'(counters_load);
			9: return 32'(powered_up);
			10: return 32'(ref_buf_en);
			11: return 32'(rf_out_en);
			12: return 32'(lock_detect);
			13: return 32'(prescaler_sel);
			14: return 32'(output_level);
			15: return 32'(outmux_sel);
			16: return 32'(core_bias);
			17: return 32'(output_halve);
			18: return 32'(halved_feed_select);
			default: return 32'(factory_test_bit);
		endcase
	endfunction
	function automatic logic [23:0] rw(input logic [13:0] r, input logic p);
		return {4'h1, 1'b0, p, 2'h2, r, SEL_RDIV};
	endfunction
	// f holds mute, gain, tristate, polarity, counter reset
	function automatic logic [23:0] cw(input logic [1:0] pd, input logic [2:0] h, l,
		input logic [4:0] f);
		return {2'h1, pd, h, l, 2'h3, f[4:1], 3'h4, f[0], 2'h2, SEL_CTRL};
	endfunction
	function automatic logic [23:0] nw(input logic g, input logic [12:0] b,
		input logic [4:0] a);
		return {2'h1, g, b, 1'b0, a, SEL_NDIV};
	endfunction
	task automatic wrap_up();
		if (fails == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input string s, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic note(input int k, input logic [31:0] v);
		q.push_back('{k, v});
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge mclk);
		#1 ->obs;
		#1;
	endtask
	always @(obs) begin
		while (q.size() > 0) begin
			nt = q.pop_front();
			check(nm[nt.k], ov(nt.k), nt.v);
		end
	end
	task automatic expire();
		check("wait", 0, 1);
		wrap_up();
	endtask
	task automatic wait_pulse();
		int i;
		for (i = 0; i < 300 && ref_div_out !== 1'b1; i++)
			@(posedge mclk) #1;
		if (i >= 300)
			expire();
	endtask
	// counts divider pulses until lock rises, or until the device powers down
	task automatic count_pulses(input bit lk);
		int i;
		n = 0;
		for (i = 0; i < 400 && (lk ? lock_detect !== 1'b1 : powered_up === 1'b1); i++) begin
			@(posedge mclk) #1;
			n += (ref_div_out === 1'b1);
		end
		if (i >= 400)
			expire();
	endtask
	task automatic seq(input logic [23:0] r, c, nv);
		host.send(r, 1'b0);
		host.send(c, 1'b0);
		repeat (6000) @(posedge mclk);
		host.send(nv, 1'b0);
	endtask
	initial begin
		logic [13:0] rv;
		logic [2:0]  c1, c2;
		rst = 1'b1;
		chip_enable = 1'b1;
		ref_in = 1'b0;
		phase_ok = 1'b0;
		ref_run = 1'b1;
		void'($urandom(32'hbb1e));
		rv = 14'($urandom_range(16383, 1));
		c1 = 3'($urandom);
		c2 = ~c1;
		note(9, 0);
		note(6, 1);
		note(8, 1);
		note(11, 0);
		settle(7);
		@(posedge mclk) rst <= 1'b0;
		seq(rw(rv, 1'b0), cw(2'h0, c2, c1, 5'b10010), nw(1'b1, 13'h1fff, 5'h1f));
		settle(8);
		note(0, rv);
		note(1, 2);
		note(2, 1);
		note(3, 31);
		note(4, 8191);
		note(5, c2);
		note(7, 1);
		note(6, 0);
		note(8, 0);
		note(9, 1);
		note(13, 1);
		note(14, 3);
		note(15, 4);
		note(16, 2);
		note(17, 1);
		note(18, 0);
		note(19, 0);
		settle(1);
		check("bsel", bs_cnt, 1);
		host.send(cw(2'h0, c2, c1, 5'b00101), 1'b1);
		host.send(nw(1'b0, 13'h3, 5'h0), 1'b0);
		host.send(24'hffffff, 1'b0);
		settle(8);
		note(5, c1);
		note(6, 1);
		note(7, 0);
		note(8, 1);
		note(3, 0);
		note(4, 3);
		note(0, rv);
		settle(1);
		host.send(cw(2'h0, c2, c1, 5'b10010), 1'b0);
		for (int p = 0; p < 2; p++) begin
			host.send(rw(14'h2, p[0]), 1'b0);
			@(posedge mclk) phase_ok <= 1'b0;
			repeat (60) @(posedge mclk);
			wait_pulse();
			@(posedge mclk) phase_ok <= 1'b1;
			#1 check("rfmute", rf_out_en, 0);
			count_pulses(1'b1);
			check("lockcnt", n, p ? 5 : 3);
			note(11, 1);
			settle(4);
		end
		@(posedge mclk) ref_run <= 1'b0;
		host.send(cw(2'h3, c2, c1, 5'b10010), 1'b0);
		@(posedge mclk) ref_run <= 1'b1;
		count_pulses(1'b0);
		check("syncpd", n, 2);
		note(10, 0);
		note(11, 0);
		note(6, 1);
		note(8, 1);
		note(12, 0);
		note(0, 2);
		settle(4);
		host.send(rw(14'h3, 1'b0), 1'b0);
		host.send(nw(1'b0, 13'h40, 5'h5), 1'b0);
		note(0, 3);
		note(4, 64);
		settle(8);
		n = bs_cnt;
		host.send(cw(2'h0, c2, c1, 5'b10010), 1'b0);
		settle(8);
		check("bswake", bs_cnt - n, 1);
		seq(rw(14'h3, 1'b0), cw(2'h0, c2, c1, 5'b10010), nw(1'b0, 13'h40, 5'h5));
		n = bs_cnt;
		host.send(cw(2'h1, c2, c1, 5'b10010), 1'b0);
		note(9, 0);
		note(10, 0);
		note(6, 1);
		settle(6);
		host.send(cw(2'h0, c2, c1, 5'b10010), 1'b0);
		@(posedge mclk) chip_enable <= 1'b0;
		note(9, 0);
		note(11, 0);
		settle(6);
		@(posedge mclk) chip_enable <= 1'b1;
		note(9, 1);
		settle(8);
		check("bsnone", bs_cnt - n, 0);
		wrap_up();
	end
endmodule
